// [hdl/byte_mul_pkg.sv]
// constants for the byte multiply instruction datapath
// assumes a 12-bit data address space split into 256-byte banks
package byte_mul_pkg;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned PROD_W       = 16;
    localparam int unsigned ADDR_W       = 12;
    localparam int unsigned BANK_W       = 4;
    localparam logic [3:0]  OPC_HI_NIB   = 4'h0;
    localparam logic [3:0]  LIT_LO_NIB   = 4'hd;
    localparam logic [6:0]  REG_OPC_TOP  = 7'h01;
    localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
    localparam logic [3:0]  ACCESS_HI_BK = 4'hf;
    localparam logic [3:0]  ACCESS_LO_BK = 4'h0;
    localparam logic [7:0]  INDEX_LIMIT  = 8'h5f;
    localparam logic [7:0]  PROD_RST     = 8'h00;

    typedef enum logic [2:0] {
        ph_idle,
        ph_decode,
        ph_read,
        ph_process,
        ph_write
    } phase_t;
endpackage : byte_mul_pkg

// [hdl/byte_mul.sv]
// byte multiply instructions: accumulator x literal and accumulator x data register
// assumes the decoder presents one instruction word with instr_valid_i while ready_o is high,
// and that data memory answers mem_data_i in the same cycle that mem_rd_o is high
`timescale 1ns/1ps
module byte_mul
    import byte_mul_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    input  wire logic              instr_valid_i,
    input  wire logic [15:0]       instr_i,
    input  wire logic [DATA_W-1:0] accum_i,
    input  wire logic [BANK_W-1:0] bank_select_register_i,
    input  wire logic              ext_set_en_i,
    input  wire logic [ADDR_W-1:0] index_base_i,
    input  wire logic [DATA_W-1:0] mem_data_i,
    output logic                   ready_o,
    output logic [ADDR_W-1:0]      mem_addr_o,
    output logic                   mem_rd_o,
    output logic [DATA_W-1:0]      product_high_byte_o,
    output logic [DATA_W-1:0]      product_low_byte_o,
    output logic                   done_o,
    output logic                   status_we_o
);

    phase_t              phase;
    logic                is_lit;
    logic                is_reg;
    logic                take;
    logic                op_reg;
    logic [DATA_W-1:0]   acc;
    logic [DATA_W-1:0]   operand;
    logic [7:0]          faddr;
    logic                abit;
    logic [PROD_W-1:0]   prod;
    logic [ADDR_W-1:0]   next_addr;

    assign is_lit = (instr_i[15:12] == OPC_HI_NIB) && (instr_i[11:8] == LIT_LO_NIB);
    assign is_reg = (instr_i[15:9] == REG_OPC_TOP);
    // other opcodes belong to other units and are simply not taken here
    assign take   = instr_valid_i && ready_o && (is_lit || is_reg);

    // one instruction cycle of four phases
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            phase   <= ph_idle;
            ready_o <= 1'b1;
        end else begin
            case (phase)
                ph_idle: begin
                    if (take) begin
                        phase   <= ph_decode;
                        ready_o <= 1'b0;
                    end
                end
                ph_decode:  phase <= ph_read;
                ph_read:    phase <= ph_process;
                ph_process: phase <= ph_write;
                ph_write: begin
                    phase   <= ph_idle;
                    ready_o <= 1'b1;
                end
                default: begin
                    phase   <= ph_idle;
                    ready_o <= 1'b1;
                end
            endcase
        end
    end

    // operands latched once; the accumulator is only ever read, never driven
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            op_reg <= 1'b0;
            acc    <= PROD_RST;
            faddr  <= PROD_RST;
            abit   <= 1'b0;
        end else if (take) begin
            op_reg <= is_reg;
            acc    <= accum_i;
            faddr  <= instr_i[7:0];
            abit   <= instr_i[8];
        end
    end

    // address resolution for the register form
    // bank, mode and index base are sampled one edge after the take
    always_comb begin
        if (abit) begin
            next_addr = {bank_select_register_i, faddr};
        // indexed window takes priority over the access bank split
        end else if (ext_set_en_i && (faddr <= INDEX_LIMIT)) begin
            next_addr = index_base_i + {4'h0, faddr};
        end else if (faddr < ACCESS_SPLIT) begin
            next_addr = {ACCESS_LO_BK, faddr};
        end else begin
            next_addr = {ACCESS_HI_BK, faddr};
        end
    end

    // read strobe only, the source register is never written
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mem_addr_o <= '0;
            mem_rd_o   <= 1'b0;
        end else begin
            mem_rd_o <= (phase == ph_decode) && op_reg;
            if (phase == ph_decode) begin
                mem_addr_o <= next_addr;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            operand <= PROD_RST;
        end else if (phase == ph_read) begin
            operand <= op_reg ? mem_data_i : faddr;
        end
    end

    // full width product, so no overflow or carry can occur
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prod <= '0;
        end else if (phase == ph_process) begin
            prod <= PROD_W'(acc) * PROD_W'(operand);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            product_high_byte_o <= PROD_RST;
            product_low_byte_o  <= PROD_RST;
            done_o              <= 1'b0;
        end else begin
            done_o <= (phase == ph_write);
            if (phase == ph_write) begin
                product_high_byte_o <= prod[PROD_W-1:DATA_W];
                product_low_byte_o  <= prod[DATA_W-1:0];
            end
        end
    end

    // status is never written by either multiply
    always_ff @(posedge clk_i) begin
        status_we_o <= 1'b0;
    end

    a_lit_product: assert property (@(posedge clk_i) disable iff (srst_i)
        (take && is_lit) |-> ##5 ({product_high_byte_o, product_low_byte_o} ==
            PROD_W'($past(accum_i, 5)) * PROD_W'($past(instr_i[7:0], 5))))
        else $error("literal product wrong");

    a_done_timing: assert property (@(posedge clk_i) disable iff (srst_i)
        take |-> ##1 (!ready_o && !done_o)[*4] ##1 (done_o && ready_o))
        else $error("multiply did not finish in four phases");

    a_done_pulse: assert property (@(posedge clk_i) disable iff (srst_i)
        done_o |=> !done_o)
        else $error("done held longer than one cycle");

    a_product_hold: assert property (@(posedge clk_i) disable iff (srst_i)
        !done_o |-> $stable(product_high_byte_o) && $stable(product_low_byte_o))
        else $error("product changed without a multiply");

    a_lit_no_read: assert property (@(posedge clk_i) disable iff (srst_i)
        (take && is_lit) |-> ##1 !mem_rd_o [*5])
        else $error("literal multiply read memory");

    a_reg_read: assert property (@(posedge clk_i) disable iff (srst_i)
        (take && is_reg) |-> ##2 mem_rd_o ##1 !mem_rd_o)
        else $error("register read strobe misplaced");

    a_bank_addr: assert property (@(posedge clk_i) disable iff (srst_i)
        (take && is_reg && instr_i[8]) |-> ##2
            (mem_addr_o == {$past(bank_select_register_i, 1), $past(instr_i[7:0], 2)}))
        else $error("banked address wrong");

    a_access_addr: assert property (@(posedge clk_i) disable iff (srst_i)
        (take && is_reg && !instr_i[8] && !ext_set_en_i) |=> !ext_set_en_i |-> ##1
            (mem_addr_o[7:0] == $past(instr_i[7:0], 2)) &&
            (mem_addr_o[11:8] == (mem_addr_o[7] ? ACCESS_HI_BK : ACCESS_LO_BK)))
        else $error("access bank address wrong");

    a_reg_product: assert property (@(posedge clk_i) disable iff (srst_i)
        (phase == ph_read && op_reg) |-> ##3
            ({product_high_byte_o, product_low_byte_o} == PROD_W'(acc) * PROD_W'($past(mem_data_i, 3))))
        else $error("register product wrong");

    a_no_status: assert property (@(posedge clk_i) disable iff (srst_i)
        !status_we_o)
        else $error("status write seen");

    a_index_addr: assert property (@(posedge clk_i) disable iff (srst_i)
        (take && is_reg && !instr_i[8] && (instr_i[7:0] <= INDEX_LIMIT)) ##1 ext_set_en_i |=>
            (mem_addr_o == $past(index_base_i, 1) + {4'h0, $past(instr_i[7:0], 2)}))
        else $error("indexed address wrong");

    a_busy_ignored: assert property (@(posedge clk_i) disable iff (srst_i)
        !ready_o |=> (phase != ph_decode))
        else $error("instruction taken while busy");

    a_idle_no_read: assert property (@(posedge clk_i) disable iff (srst_i)
        (ready_o && !take) |-> ##2 !mem_rd_o)
        else $error("read strobe without an instruction");

endmodule : byte_mul

// [sim/mem_model.sv]
// data memory model facing the multiply block's read port
// assumes a read is answered in the same cycle as the strobe
`timescale 1ns/1ps
module mem_model (
    input  wire logic        clk_i,
    input  wire logic        rd_i,
    input  wire logic [11:0] addr_i,
    output logic      [7:0]  data_o
);
    logic [7:0] last = 8'h00;

    // released bus shows the inverse, so a late sample cannot pass by luck
    always_comb data_o = rd_i ? (addr_i[7:0] ^ {addr_i[11:8], addr_i[11:8]} ^ 8'h3c) : ~last;

    always @(posedge clk_i) begin
        if (rd_i) last <= data_o;
    end
endmodule : mem_model

// [sim/byte_multiply_instructions_tb.sv]
// self-checking bench for byte_mul: corner cases, then lfsr-driven instructions
// assumes mem_model answers reads combinationally
`timescale 1ns/1ps
module byte_multiply_instructions_tb;
    import byte_mul_pkg::*;
    logic        clk_i = 0, srst_i = 1, instr_valid_i = 0, ext_set_en_i = 0;
    logic [15:0] instr_i = 16'h0000;
    logic [7:0]  accum_i = 8'h00, mem_data_i, product_high_byte_o, product_low_byte_o;
    logic [3:0]  bank_select_register_i = 4'h0;
    logic [11:0] index_base_i = 12'h000, mem_addr_o;
    logic        ready_o, mem_rd_o, done_o, status_we_o;
    logic [31:0] lfsr = 32'h6a17c57d;
    int          n_errors = 0, check_count = 0, cycles = 0;

    always #25 clk_i = ~clk_i;

    byte_mul dut (.clk_i, .srst_i, .instr_valid_i, .instr_i, .accum_i, .bank_select_register_i,
        .ext_set_en_i, .index_base_i, .mem_data_i, .ready_o, .mem_addr_o, .mem_rd_o,
        .product_high_byte_o, .product_low_byte_o, .done_o, .status_we_o);
    mem_model mem (.clk_i(clk_i), .rd_i(mem_rd_o), .addr_i(mem_addr_o), .data_o(mem_data_i));

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    function automatic logic [11:0] exp_addr(input logic [15:0] ins);
        if (ins[8]) return {bank_select_register_i, ins[7:0]};
        if (ext_set_en_i && ins[7:0] <= INDEX_LIMIT) return index_base_i + {4'h0, ins[7:0]};
        return {(ins[7] ? ACCESS_HI_BK : ACCESS_LO_BK), ins[7:0]};
    endfunction : exp_addr

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task automatic run(input logic [15:0] ins, input logic [7:0] acc);
        logic        mul;
        logic        rg;
        logic [11:0] ea;
        logic [7:0]  m;
        logic [15:0] prod;
        mul = (ins[15:8] == {OPC_HI_NIB, LIT_LO_NIB}) || (ins[15:9] == REG_OPC_TOP);
        rg = mul && ins[9];
        ea = exp_addr(ins);
        m = ea[7:0] ^ {ea[11:8], ea[11:8]} ^ 8'h3c;
        prod = {8'h00, acc} * {8'h00, (rg ? m : ins[7:0])};
        instr_valid_i = 1;
        instr_i = ins;
        accum_i = acc;
        @(posedge clk_i);
        #1;
        // a second word while busy must be ignored
        instr_valid_i = mul;
        instr_i = 16'h0dff;
        accum_i = ~acc;
        // outputs launched by edge c; after the fourth the next word is taken back to back
        for (int c = 1; c <= 4; c++) begin
            @(posedge clk_i);
            #1;
            check({15'h0, done_o}, {15'h0, (mul && c == 4)});
            check({15'h0, ready_o}, {15'h0, (!mul || c == 4)});
            check({15'h0, mem_rd_o}, {15'h0, (rg && c == 1)});
            if (rg && c == 1) check({4'h0, mem_addr_o}, {4'h0, ea});
            if (mul && c == 4) check({product_high_byte_o, product_low_byte_o}, prod);
            check({15'h0, status_we_o}, 16'h0000);
        end
    endtask : run

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            finish_test();
        end
    end

    initial begin
        logic [31:0] r;
        logic [31:0] q;
        repeat (12) @(posedge clk_i);
        #1 srst_i = 0;
        ext_set_en_i = 1;
        index_base_i = 12'hffa;
        bank_select_register_i = 4'h9;
        run(16'h0d00, 8'hff);
        run(16'h0dff, 8'hff);
        run(16'h025f, 8'h80);
        run(16'h0260, 8'hff);
        run(16'h0280, 8'h01);
        run(16'h03ff, 8'hff);
        run(16'h0e12, 8'h33);
        run(16'h0400, 8'h44);
        for (int i = 0; i < 200; i++) begin
            r = rnd();
            q = rnd();
            bank_select_register_i = r[3:0];
            ext_set_en_i = r[4];
            index_base_i = r[27:16];
            run(r[31:29] == 3'h0 ? r[15:0] : (r[5] ? {8'h0d, r[15:8]} : {7'h01, r[6], r[15:8]}), q[7:0]);
        end
        finish_test();
    end
endmodule : byte_multiply_instructions_tb
